// File: core/ppc_pkg.sv
// shared constants and types for downstream port power control
`default_nettype none
package ppc_pkg;
    localparam int PPC_NUM_PORTS = 4;
    localparam int PPC_STRAP_W = 8;
    localparam int PPC_SYNC_STAGES = 2;
    // cycles after reset release before straps are taken, so the synchroniser holds real pin levels
    localparam logic [1:0] PPC_POR_CAPTURE_DLY = 2'h2;
    localparam logic [1:0] PPC_POR_CNT_RST = 2'h0;
    localparam logic PPC_OC_LEVEL_DEFAULT = 1'h0;
    localparam logic [PPC_NUM_PORTS-1:0] PPC_PORTS_RST = 4'h0;
    localparam logic [PPC_STRAP_W-1:0] PPC_STRAP_RST = 8'h00;

    // drive side of one two-way pin
    typedef struct packed {
        logic out;
        logic oe;
    } ppc_pin_drv_t;

    localparam ppc_pin_drv_t PPC_PIN_IDLE = '{out: 1'h0, oe: 1'h0};
endpackage
`default_nettype wire

// File: core/ppc_port_power.sv
// downstream port power enables, overcurrent sense, gang mode and strap capture
`default_nettype none
module ppc_port_power import ppc_pkg::*; #(
    parameter int STRAP_W = PPC_STRAP_W,
    parameter logic OC_LEVEL = PPC_OC_LEVEL_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ext_reset_n,
    input wire logic [STRAP_W-1:0] strap_in,
    input wire logic port1_power_ctl_in,
    output logic port1_power_ctl_out,
    output logic port1_power_ctl_oe,
    input wire logic port2_power_ctl_in,
    output logic port2_power_ctl_out,
    output logic port2_power_ctl_oe,
    input wire logic port3_power_ctl_in,
    output logic port3_power_ctl_out,
    output logic port3_power_ctl_oe,
    input wire logic port4_power_ctl_in,
    output logic port4_power_ctl_out,
    output logic port4_power_ctl_oe,
    input wire logic shared_power_select_in,
    output logic shared_power_select_out,
    output logic shared_power_select_oe,
    input wire logic [PPC_NUM_PORTS-1:0] port_power_req,
    input wire logic [PPC_NUM_PORTS-1:0] port_sense_sel,
    input wire logic shared_power_req,
    output logic [PPC_NUM_PORTS-1:0] port_overcurrent,
    output logic [STRAP_W-1:0] strap_value,
    output logic gang_mode,
    output logic straps_valid
);
    localparam int SW = PPC_NUM_PORTS + 2 + STRAP_W;

    logic [SW-1:0] raw_in;
    logic [SW-1:0] sync_in;
    logic [PPC_NUM_PORTS-1:0] pin_lvl;
    logic gang_lvl;
    logic ext_rst_lvl;
    logic [STRAP_W-1:0] strap_lvl;
    logic ext_rst_q_r;
    logic [1:0] por_cnt_r;
    logic capture;
    logic run;
    logic [PPC_NUM_PORTS-1:0] sense_active;
    logic [PPC_NUM_PORTS-1:0] oc_seen;
    logic [PPC_NUM_PORTS-1:0] oc_nxt;
    logic [PPC_NUM_PORTS-1:0] en_nxt;
    logic shared_en_nxt;
    ppc_pin_drv_t drv_r [PPC_NUM_PORTS];
    ppc_pin_drv_t gang_drv_r;

    // pin roles at a glance
    // - each port pin is shared between two jobs: power enable out, or fault sense in
    // - port_sense_sel picks the job per port in per-port mode
    // - gang mode forces every port pin to sense, since the gang pin carries power
    // - the gang pin is first read as a strap, then driven as the shared enable in gang mode only

    // reset and run
    // - rst_n is the power-on reset; it clears every flag and releases every pin
    // - the external reset pin is only seen through the synchroniser
    // - while either reset holds, no pin is driven and no fault is recorded
    // - run opens one cycle after a capture, so a freshly taken gang select
    //   never meets a pin driver that still follows the old mode

    // fault handling
    // - a fault is the sensed pin sitting at OC_LEVEL while the port senses
    // - pins have pull-ups, so a floating or unused pin reads as no fault
    // - a flag stays up until the request for its port (the shared request in gang mode) goes away
    // - power is cut in the same edge that records the flag, not one later

    // limitations a user should know
    // - the fault path has three cycles of latency through the synchroniser
    // - a pulse shorter than one clock period on a sense pin may be missed
    // - straps are taken from synchronised levels; they must be steady for
    //   at least two cycles before either capture point
    // - an external reset pulse shorter than one clock period may be missed

    // trade-off: straps share the same synchroniser as the port pins, which
    // costs a couple of cycles at power-on but keeps one crossing for all pins


    // every pin level crosses into ref_clk before anything looks at it
    assign raw_in = {strap_in, ext_reset_n, shared_power_select_in, port4_power_ctl_in,
                     port3_power_ctl_in, port2_power_ctl_in, port1_power_ctl_in};

    ppc_sync2 #(.W(SW)) u_sync (
        .ref_clk(ref_clk),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    assign pin_lvl = sync_in[PPC_NUM_PORTS-1:0];
    assign gang_lvl = sync_in[PPC_NUM_PORTS];
    assign ext_rst_lvl = sync_in[PPC_NUM_PORTS+1];
    assign strap_lvl = sync_in[SW-1 -: STRAP_W];

    // power-on delay lets the synchroniser fill with live levels before the first capture
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            por_cnt_r <= PPC_POR_CNT_RST;
        end else if (por_cnt_r != PPC_POR_CAPTURE_DLY) begin
            por_cnt_r <= por_cnt_r + 2'h1;
        end
    end

    // external reset edge tracker, seen on the synchronised copy only
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_rst_q_r <= 1'h0;
        end else begin
            ext_rst_q_r <= ext_rst_lvl;
        end
    end

    assign capture = (por_cnt_r == PPC_POR_CAPTURE_DLY - 2'h1)
                   || (ext_rst_lvl && !ext_rst_q_r && por_cnt_r == PPC_POR_CAPTURE_DLY);

    // strap holding registers and the gang select taken with them
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            strap_value <= PPC_STRAP_RST;
            gang_mode <= 1'h0;
            straps_valid <= 1'h0;
        end else if (capture) begin
            strap_value <= strap_lvl;
            gang_mode <= gang_lvl;
            straps_valid <= 1'h1;
        end else if (!ext_rst_lvl) begin
            straps_valid <= 1'h0;
        end
    end

    // outputs only run once straps are held and the external reset is released
    assign run = straps_valid && ext_rst_lvl && !capture;

    // in gang mode every port pin becomes a sense input
    assign sense_active = gang_mode ? {PPC_NUM_PORTS{1'h1}} : port_sense_sel;

    always_comb begin
        oc_seen = '0;
        for (int i = 0; i < PPC_NUM_PORTS; i++) begin
            oc_seen[i] = run && sense_active[i] && (pin_lvl[i] == OC_LEVEL);
        end
    end

    // overcurrent is sticky until the hub drops its request; a new trip wins over that clear
    always_comb begin
        oc_nxt = port_overcurrent;
        for (int i = 0; i < PPC_NUM_PORTS; i++) begin
            if (oc_seen[i]) begin
                oc_nxt[i] = 1'h1;
            end else if (gang_mode ? !shared_power_req : !port_power_req[i]) begin
                oc_nxt[i] = 1'h0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            port_overcurrent <= PPC_PORTS_RST;
        end else begin
            port_overcurrent <= oc_nxt;
        end
    end

    // enables use the next flag so power falls in the same cycle the trip is recorded
    assign en_nxt = run ? (port_power_req & ~oc_nxt) : PPC_PORTS_RST;
    assign shared_en_nxt = run && shared_power_req && !(|oc_nxt);

    // per-port pin drivers: drive when used as output, release when used as sense
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < PPC_NUM_PORTS; i++) begin
                drv_r[i] <= PPC_PIN_IDLE;
            end
        end else begin
            for (int i = 0; i < PPC_NUM_PORTS; i++) begin
                drv_r[i].oe <= run && !sense_active[i];
                drv_r[i].out <= en_nxt[i] && !sense_active[i];
            end
        end
    end

    // gang pin is released while straps may be sampled, driven only in gang mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gang_drv_r <= PPC_PIN_IDLE;
        end else begin
            gang_drv_r.oe <= run && gang_mode;
            gang_drv_r.out <= gang_mode && shared_en_nxt;
        end
    end

    assign port1_power_ctl_out = drv_r[0].out;
    assign port1_power_ctl_oe = drv_r[0].oe;
    assign port2_power_ctl_out = drv_r[1].out;
    assign port2_power_ctl_oe = drv_r[1].oe;
    assign port3_power_ctl_out = drv_r[2].out;
    assign port3_power_ctl_oe = drv_r[2].oe;
    assign port4_power_ctl_out = drv_r[3].out;
    assign port4_power_ctl_oe = drv_r[3].oe;
    assign shared_power_select_out = gang_drv_r.out;
    assign shared_power_select_oe = gang_drv_r.oe;
endmodule
`default_nettype wire

// File: core/ppc_sync2.sv
// two-stage synchroniser for a bundle of pin levels
`default_nettype none
module ppc_sync2 #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // no reset: pin levels must flow through even while the block is held in reset
    always_ff @(posedge ref_clk) begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end
endmodule
`default_nettype wire

// File: verification/ppc_port_power_chk.sv
// concurrent checks on the port power control outputs
`default_nettype none
module ppc_port_power_chk import ppc_pkg::*; #(
    parameter int STRAP_W = PPC_STRAP_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ext_reset_n,
    input wire logic port1_power_ctl_in,
    input wire logic port1_power_ctl_out,
    input wire logic port1_power_ctl_oe,
    input wire logic shared_power_select_out,
    input wire logic [PPC_NUM_PORTS-1:0] port_power_req,
    input wire logic [PPC_NUM_PORTS-1:0] port_sense_sel,
    input wire logic [PPC_NUM_PORTS-1:0] port_overcurrent,
    input wire logic [STRAP_W-1:0] strap_value,
    input wire logic gang_mode,
    input wire logic straps_valid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // pin low long enough to clear the synchroniser while the port senses
    sequence oc_held;
        (straps_valid && port_sense_sel[0] && !port1_power_ctl_oe && !port1_power_ctl_in)[*3];
    endsequence
    sequence por_seq;
        !straps_valid ##1 straps_valid;
    endsequence
    rst_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !port1_power_ctl_oe && !straps_valid)
        else $error("pin driven after reset");
    por_capture_a: assert property ($rose(rst_n) && ext_reset_n |-> ##1 por_seq)
        else $error("no strap capture after reset");
    strap_hold_a: assert property (straps_valid && $past(straps_valid) |-> $stable(strap_value) && $stable(gang_mode))
        else $error("captured straps changed");
    ext_capture_a: assert property ($rose(ext_reset_n) |-> !straps_valid ##[1:5] straps_valid)
        else $error("no capture on reset pin rise");
    ext_drop_a: assert property ($fell(ext_reset_n) |-> ##[1:4] !straps_valid && !port1_power_ctl_oe)
        else $error("pin driven in external reset");
    drive_high_a: assert property (straps_valid && $past(straps_valid) && !gang_mode && port_power_req[0]
        && !port_sense_sel[0] && !port_overcurrent[0] && ext_reset_n && $past(ext_reset_n, 3)
        |=> port1_power_ctl_oe && port1_power_ctl_out)
        else $error("port power not driven high");
    oc_sense_a: assert property (oc_held |-> ##[1:2] port_overcurrent[0])
        else $error("overcurrent not flagged");
    oc_off_a: assert property (port_overcurrent[0] |-> !(port1_power_ctl_oe && port1_power_ctl_out))
        else $error("power on during overcurrent");
    gang_share_a: assert property (gang_mode |-> !port1_power_ctl_oe && !(|port_overcurrent && shared_power_select_out))
        else $error("gang mode control wrong");
endmodule
bind ppc_port_power ppc_port_power_chk #(.STRAP_W(STRAP_W)) i_ppc_port_power_chk (.*);
`default_nettype wire

// File: verification/ppc_switch_model.sv
// far side: port power switches, current monitors and pin pull-ups
`default_nettype none
module ppc_switch_model (
    input wire logic [4:0] oe,
    input wire logic [4:0] drv,
    input wire logic [3:0] fault,
    input wire logic gang_strap,
    output logic [4:0] lvl
);
    // a monitor pulls its pin low on fault, else the pull-up wins; gang pin strap level when undriven
    always_comb begin
        for (int i = 0; i < 4; i++) lvl[i] = oe[i] ? drv[i] : !fault[i];
        lvl[4] = oe[4] ? drv[4] : gang_strap;
    end
endmodule
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for port power control
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0, rst_n = 1'h0, ext_reset_n = 1'h1, shared_req = 1'h0, gang_strap = 1'h0, gm, vld;
    logic [7:0] strap_in = 8'h00, sv;
    logic [3:0] req = 4'h0, sel = 4'h0, fault = 4'h0, oc;
    logic [4:0] oe, drv, lvl;
    int seed = 66820, miscompares = 0, checked = 0;
    logic [9:0] sq[$];
    logic [12:0] pq[$];
    event se, pe;
    ppc_port_power i_ppc_port_power (.ref_clk(ref_clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n), .strap_in(strap_in),
        .port1_power_ctl_in(lvl[0]), .port1_power_ctl_out(drv[0]), .port1_power_ctl_oe(oe[0]),
        .port2_power_ctl_in(lvl[1]), .port2_power_ctl_out(drv[1]), .port2_power_ctl_oe(oe[1]),
        .port3_power_ctl_in(lvl[2]), .port3_power_ctl_out(drv[2]), .port3_power_ctl_oe(oe[2]),
        .port4_power_ctl_in(lvl[3]), .port4_power_ctl_out(drv[3]), .port4_power_ctl_oe(oe[3]),
        .shared_power_select_in(lvl[4]), .shared_power_select_out(drv[4]), .shared_power_select_oe(oe[4]),
        .port_power_req(req), .port_sense_sel(sel), .shared_power_req(shared_req), .port_overcurrent(oc),
        .strap_value(sv), .gang_mode(gm), .straps_valid(vld));
    ppc_switch_model i_ppc_switch_model (.oe(oe), .drv(drv), .fault(fault), .gang_strap(gang_strap), .lvl(lvl));
    always #4 ref_clk = ~ref_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // expectations are noted at the falling edge, where outputs have settled
    task automatic note(input bit k, input logic [12:0] v);
        @(negedge ref_clk);
        if (k) begin
            pq.push_back(v);
            -> pe;
        end else begin
            sq.push_back(v[9:0]);
            -> se;
        end
    endtask
    task automatic drive(input logic [3:0] r, s, f, input int n);
        @(posedge ref_clk);
        req <= r;
        sel <= s;
        fault <= f;
        cyc(n);
    endtask
    task automatic cmp(input string what, input logic [12:0] got, e);
        checked++;
        if (got !== e) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, e);
        end
    endtask
    // observers: oe-masked port view and captured strap view
    always @(pe) cmp("ports", {oe[3:0], drv[3:0] & oe[3:0], oc, drv[4] & oe[4]}, pq.pop_front());
    always @(se) cmp("straps", {3'h0, sv, gm, vld}, {3'h0, sq.pop_front()});
    task automatic final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        strap_in = 8'($random(seed));
        note(1, 13'h0000);
        cyc(8);
        rst_n <= 1'h1;
        cyc(3);
        note(0, {3'h0, strap_in, 2'h1});
        drive(4'hF, 4'h0, 4'h0, 2);
        note(1, {4'hF, 4'hF, 4'h0, 1'h0});
        drive(4'hF, 4'h5, 4'h1, 6);
        note(1, {4'hA, 4'hA, 4'h1, 1'h0});
        drive(4'hE, 4'h5, 4'h0, 5);
        note(1, {4'hA, 4'hA, 4'h0, 1'h0});
        @(posedge ref_clk);
        ext_reset_n <= 1'h0;
        strap_in <= 8'($random(seed));
        gang_strap <= 1'h1;
        shared_req <= 1'h1;
        drive(4'h0, 4'h0, 4'h0, 5);
        note(1, 13'h0000);
        @(posedge ref_clk);
        ext_reset_n <= 1'h1;
        cyc(7);
        note(0, {3'h0, strap_in, 2'h3});
        note(1, {4'h0, 4'h0, 4'h0, 1'h1});
        drive(4'h0, 4'h0, 4'h2, 6);
        note(1, {4'h0, 4'h0, 4'h2, 1'h0});
        cyc(2);
        final_report;
    end
    // watchdog: the sequence needs well under a hundred cycles
    initial begin
        cyc(400);
        miscompares++;
        final_report;
    end
endmodule
`default_nettype wire
